// >>> pkg/ram_access_pkg.sv
// Package for the on-chip RAM access decoder: register map, address windows, timing.
// Assumes a 25 MHz system clock and an APB register port with 32-bit data.
package ram_access_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [15:0] SYSCTL_OFFSET      = 16'hfff2;
	// Printed offset is a word index, so the byte address is four times it
	localparam logic [17:0] SYSCTL_ADDR        = 18'h3_ffc8;
	localparam logic [7:0]  SYSCTL_RESET       = 8'h0b;
	localparam int          MEM_EN_BIT         = 0;
	localparam logic [17:0] STATUS_ADDR        = 18'h3_ffcc;
	// ----------------------------------------------------------------
	// Memory geometry and address windows
	// ----------------------------------------------------------------
	localparam int          MEM_BYTES          = 512;
	localparam int          MEM_WORDS          = MEM_BYTES / 2;
	localparam int          WORD_AW            = 8;
	localparam int          CPU_AW             = 24;
	localparam logic [23:0] WIN_LO_MODE12      = 24'h0f_fd10;
	localparam logic [23:0] WIN_HI_MODE12      = 24'h0f_ff0f;
	localparam logic [23:0] WIN_LO_MODE34      = 24'hff_fd10;
	localparam logic [23:0] WIN_HI_MODE34      = 24'hff_ff0f;
	// ----------------------------------------------------------------
	// Timing: every on-chip RAM access takes two states
	// ----------------------------------------------------------------
	localparam int          ACCESS_STATES      = 2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_T1   = 2'b01,
		ST_T2   = 2'b10
	} access_state_t;
	function automatic logic in_window(input logic [23:0] a, input logic [23:0] lo,
		input logic [23:0] hi);
		in_window = (a >= lo) && (a <= hi);
	endfunction
endpackage

// >>> verilog/ram_store.sv
// Byte-lane 256x16 static store with registered read data.
// Assumes one access per cycle from the decoder.
`timescale 1ns/10ps
module ram_store
	import ram_access_pkg::*;
(
	input  wire logic                 sys_clk,
	input  wire logic                 we_hi,
	input  wire logic                 we_lo,
	input  wire logic [WORD_AW-1:0]   addr,
	input  wire logic [15:0]          wdata,
	output logic      [15:0]          rdata
);
	logic [15:0] mem [MEM_WORDS];
	always_ff @(posedge sys_clk) begin
		if (we_hi)
			mem[addr][15:8] <= wdata[15:8];
		if (we_lo)
			mem[addr][7:0] <= wdata[7:0];
		rdata <= mem[addr];
	end
endmodule // ram_store

// >>> verilog/apb_sysctl.sv
// APB slave holding the system control register and returning a status word.
// Assumes APB3 signalling; zero-wait answers.
`timescale 1ns/10ps
module apb_sysctl
	import ram_access_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [17:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [2:0]  status_in,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [7:0]  sysctl
);
	typedef struct packed {
		logic [7:0] sysctl;
	} apb_st_t;
	apb_st_t st_reg;
	apb_st_t st_next;
	logic    hit_ctl;
	logic    hit_sts;
	assign hit_ctl = (paddr == SYSCTL_ADDR);
	assign hit_sts = (paddr == STATUS_ADDR);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !(hit_ctl || hit_sts);
	assign sysctl  = st_reg.sysctl;
	always_comb begin
		st_next = st_reg;
		if (psel && penable && pwrite && hit_ctl)
			st_next.sysctl = pwdata[7:0];
	end
	// Standby has no path here, so the enable bit keeps its last write
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			st_reg.sysctl <= SYSCTL_RESET;
		else
			st_reg <= st_next;
	end
	always_comb begin
		prdata = 32'h0000_0000;
		if (hit_ctl)
			prdata = {24'h00_0000, st_reg.sysctl};
		else if (hit_sts)
			prdata = {29'h0000_0000, status_in};
	end
endmodule // apb_sysctl

// >>> verilog/onchip_ram_access_decoder.sv
// Top of the on-chip RAM access decoder: window decode, two-state access, APB control.
// Assumes the CPU holds a request until ack; mode pins are synchronous.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
module onchip_ram_access_decoder
	import ram_access_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic [2:0]        op_mode,
	input  wire logic              cpu_req,
	input  wire logic              cpu_write,
	input  wire logic              cpu_word,
	input  wire logic [CPU_AW-1:0] cpu_addr,
	input  wire logic [15:0]       cpu_wdata,
	output logic      [15:0]       cpu_rdata,
	output logic                   cpu_ack,
	output logic                   ext_sel,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [17:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr
);
	typedef struct packed {
		access_state_t     state;
		logic              high_win;
		logic              word;
		logic              odd;
		logic [15:0]       rdata;
		logic              ack;
	} top_st_t;
	top_st_t st_reg;
	top_st_t st_next;
	logic [7:0]         sysctl;
	logic               mem_en;
	logic               hit;
	logic               we_hi;
	logic               we_lo;
	logic [15:0]        ram_wdata;
	logic [15:0]        ram_rdata;
	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	apb_sysctl u_ctl (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.status_in ({st_reg.state != ST_IDLE, st_reg.high_win, mem_en}),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.sysctl    (sysctl)
	);
	assign mem_en = sysctl[MEM_EN_BIT];
	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Windows are inclusive at both ends
	always_comb begin
		if (st_reg.high_win)
			hit = in_window(cpu_addr, WIN_LO_MODE34, WIN_HI_MODE34);
		else
			hit = in_window(cpu_addr, WIN_LO_MODE12, WIN_HI_MODE12);
	end
	// Disabled or outside the window: hand the cycle to the external bus
	assign ext_sel = cpu_req && !(hit && mem_en);
	// ----------------------------------------------------------------
	// Store write lanes
	// ----------------------------------------------------------------
	// A byte rides the upper lanes; odd or even picks the stored half
	always_comb begin
		we_hi     = 1'b0;
		we_lo     = 1'b0;
		ram_wdata = cpu_wdata;
		if (st_reg.state == ST_IDLE && cpu_req && cpu_write && hit && mem_en) begin
			if (cpu_word) begin
				we_hi = 1'b1;
				we_lo = 1'b1;
			end else begin
				ram_wdata = {cpu_wdata[15:8], cpu_wdata[15:8]};
				we_hi     = !cpu_addr[0];
				we_lo     = cpu_addr[0];
			end
		end
	end
	ram_store u_ram (
		.sys_clk (sys_clk),
		.we_hi   (we_hi),
		.we_lo   (we_lo),
		.addr    (cpu_addr[WORD_AW:1]),
		.wdata   (ram_wdata),
		.rdata   (ram_rdata)
	);
	// ----------------------------------------------------------------
	// Two-state access sequencer
	// ----------------------------------------------------------------
	always_comb begin
		st_next          = st_reg;
		st_next.ack      = 1'b0;
		st_next.high_win = (op_mode == 3'd3) || (op_mode == 3'd4);
		unique case (st_reg.state)
			ST_IDLE: begin
				if (cpu_req && hit && mem_en) begin
					st_next.state = ST_T1;
					st_next.word  = cpu_word;
					st_next.odd   = cpu_addr[0];
				end
			end
			ST_T1: begin
				st_next.state = ST_T2;
				st_next.ack   = 1'b1;
				if (st_reg.word)
					st_next.rdata = ram_rdata;
				else if (st_reg.odd)
					st_next.rdata = {ram_rdata[7:0], 8'h00};
				else
					st_next.rdata = {ram_rdata[15:8], 8'h00};
			end
			ST_T2: begin
				st_next.state = ST_IDLE;
			end
			default: st_next.state = ST_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_reg.state    <= ST_IDLE;
			st_reg.high_win <= 1'b0;
			st_reg.word     <= 1'b0;
			st_reg.odd      <= 1'b0;
			st_reg.rdata    <= 16'h0000;
			st_reg.ack      <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign cpu_rdata = st_reg.rdata;
	assign cpu_ack   = st_reg.ack;
endmodule // onchip_ram_access_decoder

// >>> verif/ram_access_monitor.sv
// Port checker for the on-chip RAM access decoder.
// Assumes a bind to onchip_ram_access_decoder from tb.
`timescale 1ns/10ps
module ram_access_monitor
	import ram_access_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic [2:0]  op_mode,
	input wire logic        cpu_req,
	input wire logic        cpu_write,
	input wire logic        cpu_word,
	input wire logic [23:0] cpu_addr,
	input wire logic [15:0] cpu_rdata,
	input wire logic        cpu_ack,
	input wire logic        ext_sel,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [17:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pslverr
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire logic acc = psel && penable;
	property p_ack_pulse; cpu_ack |=> !cpu_ack; endproperty
	property p_two_state; $rose(cpu_req) && !ext_sel |-> !cpu_ack ##1 !cpu_ack ##1 cpu_ack;
	endproperty
	property p_ext_req; ext_sel |-> cpu_req; endproperty
	property p_ext_noack; ext_sel |-> ##2 !cpu_ack; endproperty
	property p_below; cpu_req && cpu_addr < WIN_LO_MODE12 |-> ext_sel; endproperty
	property p_mode34;
		cpu_req && op_mode inside {3'd3, 3'd4} && $stable(op_mode) && cpu_addr <= WIN_HI_MODE12
			|-> ext_sel;
	endproperty
	property p_byte_lane;
		cpu_ack && !$past(cpu_word, 2) && !$past(cpu_write, 2) |-> cpu_rdata[7:0] == 8'h00;
	endproperty
	property p_unmapped;
		acc && paddr != SYSCTL_ADDR && paddr != STATUS_ADDR |-> pslverr && prdata == '0;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
	a_two_state: assert property (p_two_state) else $error("access not two states");
	a_ext_req: assert property (p_ext_req) else $error("ext select without request");
	a_ext_noack: assert property (p_ext_noack) else $error("ack on external access");
	a_below: assert property (p_below) else $error("low address not external");
	a_mode34: assert property (p_mode34) else $error("low window hit in high mode");
	a_byte_lane: assert property (p_byte_lane) else $error("byte data off upper lanes");
	a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
	c_byte: cover property (cpu_ack && !$past(cpu_word, 2));
	c_ext: cover property (ext_sel);
	c_err: cover property (acc && pslverr);
endmodule // ram_access_monitor

// >>> verif/cpu_model.sv
// Processor-side model: one held request per call.
// Assumes ext_sel and cpu_ack are sampled at rising edges.
`timescale 1ns/10ps
module cpu_model (
	input wire logic         sys_clk,
	input wire logic         cpu_ack,
	input wire logic         ext_sel,
	input wire logic [15:0]  cpu_rdata,
	output logic             cpu_req,
	output logic             cpu_write,
	output logic             cpu_word,
	output logic      [23:0] cpu_addr,
	output logic      [15:0] cpu_wdata
);
	initial {cpu_req, cpu_write, cpu_word, cpu_addr, cpu_wdata} = '0;
	task automatic access(input logic w, wd, input logic [23:0] a, input logic [15:0] d,
		output logic [15:0] q, output bit ext, ok);
		ok = 0;
		ext = 0;
		cpu_req <= 1;
		cpu_write <= w;
		cpu_word <= wd;
		cpu_addr <= a;
		cpu_wdata <= d;
		for (int i = 0; i < 8 && !ok && !ext; i++) begin
			@(posedge sys_clk);
			ext = ext_sel;
			ok = cpu_ack;
			q = cpu_rdata;
		end
		// Released address and data lines show inverted values so stale data cannot pass
		cpu_req <= 0;
		cpu_addr <= ~a;
		cpu_wdata <= ~d;
		@(posedge sys_clk);
	endtask
endmodule // cpu_model

// >>> verif/tb.sv
// Self-checking bench for the RAM access decoder.
// Assumes cpu_model as processor and a byte model of the store.
`timescale 1ns/10ps
module tb;
	import ram_access_pkg::*;
	logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [2:0]  op_mode = 3'd1;
	logic [17:0] paddr = '0;
	logic [15:0] cpu_wdata, cpu_rdata;
	logic [31:0] pwdata = '0, prdata;
	logic        cpu_req, cpu_write, cpu_word, cpu_ack, ext_sel, pready, pslverr;
	logic [23:0] cpu_addr;
	logic [7:0]  mem[512];
	int          miscompares = 0, samples_checked = 0;
	bit          en = 1;
	always #20 sys_clk = ~sys_clk;
	onchip_ram_access_decoder u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .op_mode(op_mode),
		.cpu_req(cpu_req), .cpu_write(cpu_write), .cpu_word(cpu_word), .cpu_addr(cpu_addr),
		.cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .ext_sel(ext_sel),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	cpu_model cpu (.sys_clk(sys_clk), .cpu_ack(cpu_ack), .ext_sel(ext_sel),
		.cpu_rdata(cpu_rdata), .cpu_req(cpu_req), .cpu_write(cpu_write),
		.cpu_word(cpu_word), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata));
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, g);
		samples_checked++;
		if (e !== g) begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic apb(bit w, logic [17:0] a, logic [31:0] d, output logic [31:0] q,
		output logic err);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		for (int i = 0; i <= 8; i++) begin
			@(posedge sys_clk);
			q = prdata;
			err = pslverr;
			if (pready === 1'b1)
				break;
			if (i == 8) begin
				miscompares++;
				give_verdict();
			end
		end
		psel <= 0;
		penable <= 0;
		@(posedge sys_clk);
	endtask
	task automatic ram(bit w, wd, logic [23:0] a, logic [15:0] d);
		logic [15:0] q;
		bit          ext, ok;
		logic [23:0] lo = op_mode inside {3'd3, 3'd4} ? WIN_LO_MODE34 : WIN_LO_MODE12;
		bit          hit = en && a >= lo && a <= lo + 24'h00_01ff;
		int          o = int'(a - lo);
		cpu.access(w, wd, a, d, q, ext, ok);
		if (!ok && !ext) begin
			miscompares++;
			give_verdict();
		end
		chk("ext_sel", !hit, ext);
		if (hit && w) mem[o] = d[15:8];
		if (hit && w && wd) mem[o + 1] = d[7:0];
		if (hit && !w && wd) chk("word", {mem[o], mem[o + 1]}, q);
		if (hit && !w && !wd) chk("byte", {mem[o], 8'h00}, q);
	endtask
	initial begin
		logic [31:0] q;
		logic        e;
		int          a;
		bit          wd;
		void'($urandom(32'hdc7d5be8));
		repeat (16) @(posedge sys_clk);
		rst_n <= 1;
		repeat (2) @(posedge sys_clk);
		apb(0, SYSCTL_ADDR, 0, q, e);
		chk("sysctl", 32'h0000_000b, q);
		apb(0, 18'h0_ffd0, 0, q, e);
		chk("pslverr", 1, e);
		for (a = 0; a < 512; a += 2) ram(1, 1, WIN_LO_MODE12 + 24'(a), 16'($urandom));
		for (int i = 0; i < 300; i++) begin
			if (i % 40 == 0) begin
				op_mode <= 3'($urandom_range(1, 4));
				en = $urandom_range(0, 2) != 0;
				apb(1, SYSCTL_ADDR, {31'h0000_0005, en}, q, e);
				apb(0, SYSCTL_ADDR, 0, q, e);
				chk("enable", en, q[0]);
			end
			wd = $urandom_range(0, 1);
			a = $urandom_range(0, 520) - 4;
			a = ($urandom_range(0, 1) ? WIN_LO_MODE34 : WIN_LO_MODE12) + a;
			ram($urandom_range(0, 1), wd, 24'(a) & ~{23'h0, wd}, 16'($urandom));
		end
		rst_n <= 0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1;
		en = 1;
		repeat (2) @(posedge sys_clk);
		apb(0, SYSCTL_ADDR, 0, q, e);
		chk("sysctl", 32'h0000_000b, q);
		give_verdict();
	end
endmodule // tb
bind onchip_ram_access_decoder ram_access_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n),
	.op_mode(op_mode), .cpu_req(cpu_req), .cpu_write(cpu_write), .cpu_word(cpu_word),
	.cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .ext_sel(ext_sel),
	.psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pslverr(pslverr));
